// [design/lcd_consts.svh]
`ifndef LCD_CONSTS_SVH
`define LCD_CONSTS_SVH

// ****************************************************************
// register indices (byte address = 4 * index)
// ****************************************************************
`define LCD_IDX_IRQ_FLAGS   10'h00c
`define LCD_IDX_IRQ_ENABLES 10'h08c
`define LCD_IDX_PRESCALE    10'h10e
`define LCD_IDX_CONTROL     10'h10f
`define LCD_IDX_PIXEL_BASE  10'h110
`define LCD_IDX_PIXEL_LAST  10'h11f

// ****************************************************************
// field positions and reset values
// ****************************************************************
`define LCD_FRAME_IRQ_BIT   3
`define LCD_FRAME_IRQ_POS   7
`define LCD_CTRL_RESET      8'h00
`define LCD_PRESCALE_RESET  4'h0
`define LCD_CTRL_WRITE_MASK 8'hdf

// ****************************************************************
// timing counts
// ****************************************************************
`define LCD_SYS_DIV_LAST    8'hff
`define LCD_SLOTS_NORMAL    7'h7f
`define LCD_SLOTS_THREE     7'h5f
`define LCD_PIXEL_REGS      16
`define LCD_PIXEL_LAST      4'hf
`define LCD_RC_NOMINAL_KHZ  14

`endif

// [design/lcd_pkg.sv]
package lcd_pkg;

    // control register layout, bit 7 down to bit 0
    typedef struct packed {
        logic       drive_enable;
        logic       stop_in_sleep;
        logic       unused_zero;
        logic       voltage_generator_on;
        logic [1:0] timing_source_select;
        logic [1:0] common_count_select;
    } lcd_ctrl_t;

    // pixel fetch sequencer
    typedef enum logic [2:0] {
        LCD_F_IDLE = 3'b001,
        LCD_F_READ = 3'b010,
        LCD_F_HOLD = 3'b100
    } lcd_fetch_t;

endpackage

// [design/lcd_frame_timing.sv]
// Contract
// [R01] drive_enable set drives the panel; clear turns all drive off
// [R02] stop_in_sleep set halts module in processor sleep; clear keeps displaying
// [R03] control bit 5 and prescale bits 7..4 always read zero
// [R04] voltage_generator_on powers the internal drive-voltage generator
// [R05] timing_source_select: 00 sysclk/256, 01 Timer1 input, 1x RC oscillator
// [R06] common_count_select 00..11 gives one to four commons
// [R07] one common uses static bias, more commons use one-third bias
// [R08] static, two and four commons: frame = source / (128*(prescale+1))
// [R09] three commons: frame = source / (96*(prescale+1))
// [R10] prescale register holds four read/write bits, reset zero
// [R11] RC oscillator powered down unless selected and module enabled
// [R12] system-clock divider fixed at 256; rate set only by prescale
// [R13] software enables Timer1 oscillator to use it as source
// [R14] each frame starts at leading edge of the first common
// [R15] frame flag set right after pixel fetch, fixed time before boundary
// [R16] next frame's fetch begins within the frame write window
// [R17] each pixel bit controls exactly one segment and common pair
// [R18] pixel bit one drives pixel dark, zero leaves it clear
// [R19] unused pixel bits stay ordinary read/write storage
// [R20] pixel array is sixteen eight-bit registers
// [R21] frame flag in bit 7 of irq flags, enable in bit 7 of enables
// [R22] sleep with stop_in_sleep stops at once, all lines at minimum level
// [R23] frame flag stays set until software clears it
//
// Decided for this implementation: the APB register port.
`include "lcd_consts.svh"

module lcd_frame_timing
    import lcd_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        arst_n_in,
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [11:0] paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic      [31:0] prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    input  wire logic        sleep_in,
    input  wire logic        timer1_clock_input_in,
    input  wire logic        timer1_osc_enable_in,
    input  wire logic        rc_osc_clock_in,
    output logic      [3:0]  common_drive_out,
    output logic      [31:0] segment_drive_out,
    output logic             frame_polarity_out,
    output logic             bias_third_out,
    output logic             voltage_generator_on_out,
    output logic             rc_osc_enable_out,
    output logic             panel_drive_out,
    output logic             frame_irq_out
);

    // ****************************************************************
    // declarations
    // ****************************************************************
    lcd_ctrl_t   ctrl;
    logic [3:0]  frame_prescale_value;
    logic        frame_irq_flag;
    logic        frame_irq_enable;
    logic [7:0]  pixel_mem [`LCD_PIXEL_REGS];
    logic [9:0]  reg_idx;
    logic        wr_en;
    logic        rd_setup;
    logic        idx_pixel;
    logic        idx_mapped;
    logic [7:0]  next_rdata;
    logic        flag_clear;
    logic        run;
    logic [7:0]  sys_div;
    logic        sys_div_tick;
    logic        t1_prev;
    logic        rc_prev;
    logic        src_tick;
    logic [3:0]  presc_cnt;
    logic        slot_tick;
    logic [6:0]  slot;
    logic [6:0]  slot_last;
    logic [1:0]  com_idx;
    lcd_fetch_t  fstate;
    logic [3:0]  fidx;
    logic        fetch_done;
    logic [127:0] shadow;
    logic [127:0] display;

    // ****************************************************************
    // apb slave
    // ****************************************************************
    assign reg_idx   = paddr_in[11:2];
    assign wr_en     = psel_in & penable_in & pready_out & pwrite_in;
    assign rd_setup  = psel_in & ~penable_in;
    assign idx_pixel = (reg_idx >= `LCD_IDX_PIXEL_BASE) && (reg_idx <= `LCD_IDX_PIXEL_LAST);
    assign idx_mapped = idx_pixel || (reg_idx == `LCD_IDX_IRQ_FLAGS) ||
                        (reg_idx == `LCD_IDX_IRQ_ENABLES) ||
                        (reg_idx == `LCD_IDX_PRESCALE) || (reg_idx == `LCD_IDX_CONTROL);

    // read mux; unimplemented bits come back as zero
    always_comb begin
        next_rdata = 8'h00;
        if (idx_pixel) begin
            next_rdata = pixel_mem[reg_idx[3:0]];
        end else begin
            case (reg_idx)
                `LCD_IDX_IRQ_FLAGS:   next_rdata = {frame_irq_flag, 7'h00};     // [R21]
                `LCD_IDX_IRQ_ENABLES: next_rdata = {frame_irq_enable, 7'h00};   // [R21]
                `LCD_IDX_PRESCALE:    next_rdata = {4'h0, frame_prescale_value}; // [R03]
                `LCD_IDX_CONTROL:     next_rdata = ctrl & `LCD_CTRL_WRITE_MASK;  // [R03]
                default:              next_rdata = 8'h00;
            endcase
        end
    end

    // one wait-free access: answer is ready in the first access cycle
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            pready_out  <= 1'b0;
            prdata_out  <= 32'h0000_0000;
            pslverr_out <= 1'b0;
        end else begin
            pready_out <= rd_setup;
            if (rd_setup) begin
                prdata_out  <= {24'h00_0000, next_rdata};
                pslverr_out <= ~idx_mapped;
            end else begin
                pslverr_out <= 1'b0;
            end
        end
    end

    // control and prescale registers; bit 5 and prescale top never stored
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ctrl                 <= `LCD_CTRL_RESET;
            frame_prescale_value <= `LCD_PRESCALE_RESET;         // [R10]
        end else if (wr_en) begin
            if (reg_idx == `LCD_IDX_CONTROL) begin
                ctrl <= pwdata_in[7:0] & `LCD_CTRL_WRITE_MASK;   // [R03]
            end
            if (reg_idx == `LCD_IDX_PRESCALE) begin
                frame_prescale_value <= pwdata_in[3:0];          // [R10]
            end
        end
    end

    // pixel storage; every bit is plain memory whatever the mode
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            for (int i = 0; i < `LCD_PIXEL_REGS; i++) begin
                pixel_mem[i] <= 8'h00;                            // [R20]
            end
        end else if (wr_en && idx_pixel) begin
            pixel_mem[reg_idx[3:0]] <= pwdata_in[7:0];            // [R19]
        end
    end

    // interrupt flag and enable; a fetch completing wins over a clear
    assign flag_clear = wr_en && (reg_idx == `LCD_IDX_IRQ_FLAGS) &&
                        !pwdata_in[`LCD_FRAME_IRQ_POS];
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            frame_irq_flag   <= 1'b0;
            frame_irq_enable <= 1'b0;
        end else begin
            if (fetch_done) begin
                frame_irq_flag <= 1'b1;                           // [R15]
            end else if (wr_en && (reg_idx == `LCD_IDX_IRQ_FLAGS)) begin
                frame_irq_flag <= pwdata_in[`LCD_FRAME_IRQ_POS];  // [R23]
            end
            if (wr_en && (reg_idx == `LCD_IDX_IRQ_ENABLES)) begin
                frame_irq_enable <= pwdata_in[`LCD_FRAME_IRQ_POS]; // [R21]
            end
        end
    end

    // ****************************************************************
    // timing sources
    // ****************************************************************
    // module runs only when enabled and not parked by sleep
    assign run = ctrl.drive_enable & ~(sleep_in & ctrl.stop_in_sleep);   // [R01] [R02]

    // fixed divide by 256, no software access to the ratio
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            sys_div <= 8'h00;
        end else begin
            sys_div <= sys_div + 8'h01;                           // [R12]
        end
    end
    assign sys_div_tick = (sys_div == `LCD_SYS_DIV_LAST);

    // slow source edges; both pins are already in the clk_in domain
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            t1_prev <= 1'b0;
            rc_prev <= 1'b0;
        end else begin
            t1_prev <= timer1_clock_input_in;
            rc_prev <= rc_osc_clock_in;
        end
    end

    // source mux; Timer1 only counts once its oscillator is enabled
    always_comb begin
        case (ctrl.timing_source_select)
            2'b00:   src_tick = sys_div_tick;                                // [R05]
            2'b01:   src_tick = timer1_clock_input_in & ~t1_prev &
                                timer1_osc_enable_in;                        // [R05] [R13]
            default: src_tick = rc_osc_clock_in & ~rc_prev;                  // [R05]
        endcase
    end

    // ****************************************************************
    // frame timing
    // ****************************************************************
    // prescaler: one slot per (prescale + 1) source ticks
    assign slot_tick = run & src_tick & (presc_cnt == frame_prescale_value);
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            presc_cnt <= 4'h0;
        end else if (!run || slot_tick) begin
            presc_cnt <= 4'h0;
        end else if (src_tick) begin
            presc_cnt <= presc_cnt + 4'h1;                        // [R08] [R09]
        end
    end

    // three commons fit 32 slots each into 96, all else use 128
    assign slot_last = (ctrl.common_count_select == 2'b10) ? `LCD_SLOTS_THREE
                                                           : `LCD_SLOTS_NORMAL; // [R08] [R09]

    // slot counter; wrap to zero is the frame boundary
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            slot               <= 7'h00;
            frame_polarity_out <= 1'b0;
        end else if (!run) begin
            slot               <= 7'h00;                          // [R22]
            frame_polarity_out <= 1'b0;
        end else if (slot_tick) begin
            if (slot >= slot_last) begin
                slot               <= 7'h00;                      // [R14]
                frame_polarity_out <= ~frame_polarity_out;
            end else begin
                slot <= slot + 7'h01;
            end
        end
    end

    // active common from slot position and mode
    always_comb begin
        case (ctrl.common_count_select)
            2'b00:   com_idx = 2'd0;                              // [R06]
            2'b01:   com_idx = {1'b0, slot[6]};                   // [R06]
            default: com_idx = slot[6:5];                         // [R06]
        endcase
    end

    // ****************************************************************
    // pixel fetch
    // ****************************************************************
    // fetch runs in the last slot so the flag precedes the boundary
    // by a fixed time; needs 16 clocks, shorter than one slot of the sysclk/256 source
    assign fetch_done = (fstate == LCD_F_READ) && (fidx == `LCD_PIXEL_LAST);
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            fstate  <= LCD_F_IDLE;
            fidx    <= 4'h0;
            shadow  <= '0;
            display <= '0;
        end else if (!run) begin
            fstate <= LCD_F_IDLE;
            fidx   <= 4'h0;
        end else begin
            case (fstate)
                LCD_F_IDLE: begin
                    if (slot_tick && (slot == slot_last - 7'h01)) begin
                        fstate <= LCD_F_READ;                     // [R16]
                        fidx   <= 4'h0;
                    end
                end
                LCD_F_READ: begin
                    shadow[fidx*8 +: 8] <= pixel_mem[fidx];       // [R17]
                    fidx <= fidx + 4'h1;
                    if (fidx == `LCD_PIXEL_LAST) begin
                        fstate <= LCD_F_HOLD;                     // [R15]
                    end
                end
                LCD_F_HOLD: begin
                    if (slot_tick && (slot >= slot_last)) begin
                        display <= shadow;                        // [R14]
                        fstate  <= LCD_F_IDLE;
                    end
                end
                default: fstate <= LCD_F_IDLE;
            endcase
        end
    end

    // ****************************************************************
    // panel drive outputs
    // ****************************************************************
    // registered drive; everything low is the minimum-voltage state
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            common_drive_out  <= 4'h0;
            segment_drive_out <= 32'h0000_0000;
            panel_drive_out   <= 1'b0;
        end else if (!run) begin
            common_drive_out  <= 4'h0;                            // [R01] [R22]
            segment_drive_out <= 32'h0000_0000;                   // [R01] [R22]
            panel_drive_out   <= 1'b0;
        end else begin
            common_drive_out  <= 4'h1 << com_idx;                 // [R06] [R14]
            segment_drive_out <= display[com_idx*32 +: 32];       // [R17] [R18]
            panel_drive_out   <= 1'b1;                            // [R01]
        end
    end

    // bias, generator and oscillator power controls, and the frame interrupt output
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            bias_third_out           <= 1'b0;
            voltage_generator_on_out <= 1'b0;
            rc_osc_enable_out        <= 1'b0;
            frame_irq_out            <= 1'b0;
        end else begin
            bias_third_out           <= (ctrl.common_count_select != 2'b00);      // [R07]
            voltage_generator_on_out <= ctrl.voltage_generator_on & run;          // [R04]
            rc_osc_enable_out        <= ctrl.timing_source_select[1] & run;       // [R11]
            frame_irq_out            <= frame_irq_flag & frame_irq_enable;        // [R21]
        end
    end

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking @(posedge clk_in); endclocking
    default disable iff (!arst_n_in);

    a_ctrl_bit5_zero: assert property (pready_out && $past(rd_setup) &&
        $past(reg_idx) == `LCD_IDX_CONTROL |-> prdata_out[5] == 1'b0) // [R03]
        else $error("control bit 5 read back nonzero");
    a_drive_off_idle: assert property (!ctrl.drive_enable |=>
        common_drive_out == 4'h0 && segment_drive_out == 32'h0) // [R01]
        else $error("panel driven while drive disabled");
    a_sleep_stop_now: assert property (sleep_in && ctrl.stop_in_sleep |=>
        common_drive_out == 4'h0 && !panel_drive_out) // [R22]
        else $error("drive kept during sleep with stop set");
    a_voltage_generator_on_power_up: assert property ($rose(ctrl.voltage_generator_on) && run
        |=> voltage_generator_on_out) // [R04]
        else $error("voltage generator not powered");
    a_rc_osc_off: assert property (!ctrl.timing_source_select[1] |=> !rc_osc_enable_out) // [R11]
        else $error("rc oscillator powered when unselected");
    a_bias_static: assert property (ctrl.common_count_select == 2'b00 |=> !bias_third_out) // [R07]
        else $error("third bias in static mode");
    a_sysdiv_fixed: assert property (sys_div_tick |=> !sys_div_tick [*8]) // [R12]
        else $error("system divider ticks too often");
    a_three_com_len: assert property (ctrl.common_count_select == 2'b10 && $stable(ctrl)
        |-> slot <= 7'h5f) // [R09]
        else $error("three-common frame longer than 96 slots");
    a_fetch_flag_set: assert property (fetch_done |=> frame_irq_flag) // [R15]
        else $error("flag not set after pixel fetch");
    a_flag_sticky: assert property (frame_irq_flag && !flag_clear |=> frame_irq_flag) // [R23]
        else $error("frame flag dropped without software clear");
    a_fetch_bounded: assert property (fstate == LCD_F_READ |-> ##[1:16] fstate != LCD_F_READ) // [R16]
        else $error("pixel fetch overran 16 cycles");
    a_common_onehot: assert property ($onehot0(common_drive_out)) // [R06]
        else $error("more than one common active");
    a_frame_start_com: assert property (slot_tick && slot >= slot_last && run
        |=> ##1 (common_drive_out == 4'h1 || common_drive_out == 4'h0)) // [R14]
        else $error("frame did not start on first common");

endmodule

// [verif/lcd_panel_model.sv]
// ****************************************
// passive glass: latches what each common sees
// ****************************************
module lcd_panel_model (
    input  wire logic        clk_in,
    input  wire logic        arst_n_in,
    input  wire logic        clear_in,
    input  wire logic        panel_drive_in,
    input  wire logic [3:0]  common_drive_in,
    input  wire logic [31:0] segment_drive_in,
    output logic      [31:0] image_out [4],
    output logic      [3:0]  seen_out
);
    timeunit 1ns;
    timeprecision 1ps;

    // each segment bit lands on one common row, 1 reads as dark
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            seen_out <= 4'h0;
            for (int c = 0; c < 4; c++) image_out[c] <= 32'h0;
        end else if (clear_in) begin
            seen_out <= 4'h0;
        end else if (panel_drive_in) begin
            for (int c = 0; c < 4; c++) begin
                if (common_drive_in[c]) begin
                    image_out[c] <= segment_drive_in;
                    seen_out[c]  <= 1'b1;
                end
            end
        end
    end
endmodule

// [verif/tb_top.sv]
`include "lcd_consts.svh"

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************
    // stimulus and observation
    // ****************************************
    localparam logic [11:0] a_flg = {`LCD_IDX_IRQ_FLAGS, 2'b00};
    localparam logic [11:0] a_en  = {`LCD_IDX_IRQ_ENABLES, 2'b00};
    localparam logic [11:0] a_ps  = {`LCD_IDX_PRESCALE, 2'b00};
    localparam logic [11:0] a_ctl = {`LCD_IDX_CONTROL, 2'b00};
    localparam logic [11:0] a_pix = {`LCD_IDX_PIXEL_BASE, 2'b00};
    localparam logic [7:0]  row_c [5] = '{8'h9c, 8'h8a, 8'h87, 8'h95, 8'h82};
    localparam logic [3:0]  row_p [5] = '{4'h1, 4'h1, 4'h1, 4'h2, 4'h0};
    logic        clk_in = 1'b0, arst_n_in = 1'b0, psel_in = 1'b0, penable_in = 1'b0;
    logic        pwrite_in = 1'b0, sleep_in = 1'b0, t1_in = 1'b0, t1_en_in = 1'b0;
    logic        rc_in = 1'b0, clr_in = 1'b0, pready_out, pslverr_out, pol, bias, vg, rce;
    logic        pd, irq;
    logic [11:0] paddr_in = 12'h0;
    logic [31:0] pwdata_in = 32'h0, prdata_out, seg, rd, img [4];
    logic [3:0]  com, seen;
    logic [1:0]  rc_cnt = 2'h0;
    int          t1_cnt = 0, cyc = 0, err_total = 0, comparisons = 0, n, ex;

    lcd_frame_timing lcd_frame_timing_i (
        .clk_in(clk_in), .arst_n_in(arst_n_in), .psel_in(psel_in),
        .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
        .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
        .pslverr_out(pslverr_out), .sleep_in(sleep_in), .timer1_clock_input_in(t1_in),
        .timer1_osc_enable_in(t1_en_in), .rc_osc_clock_in(rc_in),
        .common_drive_out(com), .segment_drive_out(seg), .frame_polarity_out(pol),
        .bias_third_out(bias), .voltage_generator_on_out(vg), .rc_osc_enable_out(rce),
        .panel_drive_out(pd), .frame_irq_out(irq));

    lcd_panel_model lcd_panel_model_i (
        .clk_in(clk_in), .arst_n_in(arst_n_in), .clear_in(clr_in), .panel_drive_in(pd),
        .common_drive_in(com), .segment_drive_in(seg), .image_out(img), .seen_out(seen));

    always #4 clk_in = ~clk_in;

    // rc source rises every 4 clocks, timer1 every 6, so a frame length names its source
    always @(posedge clk_in) begin
        rc_cnt <= rc_cnt + 2'h1;
        rc_in  <= rc_cnt[1];
        t1_cnt <= (t1_cnt == 5) ? 0 : t1_cnt + 1;
        t1_in  <= (t1_cnt < 3);
    end

    // hang guard, well above the slowest system-clock frame pair
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 95000) begin
            err_total++;
            close_out();
        end
    end

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic chk(input string nm, input logic [31:0] seen_v, input logic [31:0] exp_v);
        comparisons++;
        if (seen_v !== exp_v) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, exp_v, seen_v);
        end
    endtask

    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int g;
        @(posedge clk_in);
        psel_in   <= 1'b1;
        pwrite_in <= w;
        paddr_in  <= a;
        pwdata_in <= d;
        @(posedge clk_in);
        penable_in <= 1'b1;
        g = 0;
        do begin
            @(posedge clk_in);
            g++;
        end while (pready_out !== 1'b1 && g < 50);
        if (pready_out !== 1'b1) err_total++;
        rd = prdata_out;
        psel_in    <= 1'b0;
        penable_in <= 1'b0;
    endtask

    task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, rd, e);
    endtask

    // skips to a boundary, then counts clocks to the next one
    task automatic frame_len(output int len);
        logic p;
        p = pol;
        len = 0;
        while (pol === p && len < 60000) begin
            @(posedge clk_in);
            len++;
        end
        p = pol;
        len = 0;
        while (pol === p && len < 60000) begin
            @(posedge clk_in);
            len++;
        end
    endtask

    function automatic logic [7:0] pat(input int i);
        return 8'(i * 17) ^ 8'ha5;
    endfunction

    task automatic close_out();
        $display("compares %0d errors %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ****************************************
    // test sequence
    // ****************************************
    initial begin
        repeat (3) @(posedge clk_in);
        arst_n_in <= 1'b1;
        t1_en_in  <= 1'b1;
        rdc("ctl_rst", a_ctl, 32'h0);
        rdc("ps_rst", a_ps, 32'h0);
        rdc("flg_rst", a_flg, 32'h0);
        apb(1'b1, a_ps, 32'hff);
        rdc("ps_rw", a_ps, 32'h0f);
        apb(1'b1, a_ctl, 32'h7f);
        rdc("ctl_rw", a_ctl, 32'h5f);
        apb(1'b0, a_pix + 12'h040, 32'h0);
        chk("beyond_pixels", {31'h0, pslverr_out}, 32'h1);
        for (int i = 0; i < 16; i++) apb(1'b1, a_pix + 12'(4 * i), {24'h0, pat(i)});
        for (int i = 0; i < 16; i++) rdc("pixel", a_pix + 12'(4 * i), {24'h0, pat(i)});
        // every source code and common count, counters restarted per row
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, a_ps, {28'h0, row_p[i]});
            apb(1'b1, a_ctl, 32'h0);
            apb(1'b1, a_ctl, {24'h0, row_c[i]});
            clr_in <= 1'b1;
            @(posedge clk_in);
            clr_in <= 1'b0;
            frame_len(n);
            ex = (row_c[i][1:0] == 2'b10 ? 96 : 128) * (row_p[i] + 1)
                 * (row_c[i][3] ? 4 : row_c[i][2] ? 6 : 256);
            chk("frame_len", 32'(n), 32'(ex));
            chk("commons", {28'h0, seen}, 32'((2 << row_c[i][1:0]) - 1));
            chk("bias", {31'h0, bias}, {31'h0, row_c[i][1:0] != 2'b00});
            chk("voltage_generator_on", {31'h0, vg}, {31'h0, row_c[i][4]});
            chk("rc_en", {31'h0, rce}, {31'h0, row_c[i][3]});
        end
        // just past a boundary the next fetch is far away
        rdc("flag_set", a_flg, 32'h80);
        rdc("flag_stays", a_flg, 32'h80);
        chk("irq_masked", {31'h0, irq}, 32'h0);
        apb(1'b1, a_en, 32'h80);
        repeat (2) @(posedge clk_in);
        chk("irq_on", {31'h0, irq}, 32'h1);
        apb(1'b1, a_flg, 32'h0);
        rdc("flag_clr", a_flg, 32'h0);
        apb(1'b1, a_ps, 32'h0);
        apb(1'b1, a_ctl, 32'h0);
        apb(1'b1, a_ctl, 32'h8f);
        repeat (3) frame_len(n);
        @(posedge clk_in);
        chk("first_common", {28'h0, com}, 32'h1);
        for (int c = 0; c < 4; c++)
            chk("image", img[c], {pat(4*c+3), pat(4*c+2), pat(4*c+1), pat(4*c)});
        sleep_in <= 1'b1;
        frame_len(n);
        chk("sleep_run", 32'(n), 32'd512);
        apb(1'b1, a_ctl, 32'hcf);
        repeat (2) @(posedge clk_in);
        chk("sleep_stop", {26'h0, |seg, com, pd}, 32'h0);
        sleep_in <= 1'b0;
        apb(1'b1, a_ctl, 32'h0f);
        repeat (2) @(posedge clk_in);
        chk("disabled", {26'h0, com, pd, rce}, 32'h0);
        close_out();
    end
endmodule
